// [bench/dual_jk_edge_flip_flop_test.sv]
`timescale 1ns/1ps
`default_nettype none
module dual_jk_edge_flip_flop_test;
  logic       clk;
  logic       rst;
  logic       ce;
  logic [1:0] edge_clock;
  logic [1:0] j_in;
  logic [1:0] k_n_in;
  logic [1:0] pre_n;
  logic [1:0] clr_n;
  logic [1:0] state_out;
  logic [1:0] state_out_n;
  logic [1:0] st;
  int         n_errors;
  int         comparisons;
  // {J, K-bar, expected state} from a cleared start
  localparam logic [2:0] SEQ [8] = '{3'h7, 3'h4, 3'h5, 3'h3, 3'h0, 3'h2, 3'h5, 3'h0};
  // ==========================================================
  // Clock, partner and block
  initial clk = 1'b0;
  always #2 clk = ~clk;
  pin_partner drv (.clk(clk), .edge_clock(edge_clock), .j_in(j_in), .k_n_in(k_n_in),
                   .direct_preset_n(pre_n), .direct_clear_n(clr_n));
  dual_jk_edge_flip_flop uut (.clk(clk), .rst(rst), .ce(ce), .edge_clock(edge_clock),
                              .j_in(j_in), .k_n_in(k_n_in), .direct_preset_n(pre_n),
                              .direct_clear_n(clr_n), .state_out(state_out),
                              .state_out_n(state_out_n));
  // ==========================================================
  // Checking
  function automatic logic [1:0] pair(input int c);
    return {state_out[c], state_out_n[c]};
  endfunction : pair
  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: outputs %b, wanted %b", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // ==========================================================
  // Scenarios
  task automatic t_truth(input int c);
    for (int i = 0; i < 8; i++) begin
      drv.pins(c, SEQ[i][2], SEQ[i][1], 1'b1, 1'b1);
      check(pair(c), {st[c], ~st[c]});
      drv.pulse(c);
      st[c] = SEQ[i][0];
      check(pair(c), {st[c], ~st[c]});
      check(pair(1 - c), {st[1 - c], ~st[1 - c]});
    end
  endtask : t_truth
  task automatic t_dtype(input int c);
    for (int i = 0; i < 3; i++) begin
      drv.pins(c, i[0] ^ 1'b1, i[0] ^ 1'b1, 1'b1, 1'b1);
      drv.pulse(c);
      check(pair(c), {i[0] ^ 1'b1, i[0]});
    end
  endtask : t_dtype
  // Clock edges during direct low would flip the state if not ignored
  task automatic t_direct(input int c);
    drv.pins(c, 1'b1, 1'b1, 1'b1, 1'b0);
    check(pair(c), 2'h1);
    drv.pulse(c);
    check(pair(c), 2'h1);
    drv.pins(c, 1'b1, 1'b1, 1'b1, 1'b1);
    check(pair(c), 2'h1);
    drv.pins(c, 1'b0, 1'b0, 1'b0, 1'b1);
    check(pair(c), 2'h2);
    drv.pulse(c);
    check(pair(c), 2'h2);
    drv.pins(c, 1'b0, 1'b0, 1'b1, 1'b1);
    check(pair(c), 2'h2);
    drv.pulse(c);
    check(pair(c), 2'h1);
    drv.pins(c, 1'b1, 1'b1, 1'b0, 1'b0);
    check(pair(c), 2'h3);
    check(pair(1 - c), {st[1 - c], ~st[1 - c]});
    drv.pins(c, 1'b1, 1'b1, 1'b1, 1'b1);
    check(pair(c), 2'h2);
    st[c] = 1'b1;
  endtask : t_direct
  // A pulse wholly inside ce low is never seen; the next one acts
  task automatic t_freeze(input int c);
    drv.pins(c, 1'b1, 1'b0, 1'b1, 1'b1);
    ce <= 1'b0;
    drv.pulse(c);
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    check(pair(c), {st[c], ~st[c]});
    drv.pulse(c);
    st[c] = ~st[c];
    check(pair(c), {st[c], ~st[c]});
    check(pair(1 - c), {st[1 - c], ~st[1 - c]});
  endtask : t_freeze
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    st = 2'h0;
    n_errors = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(pair(0), 2'h1);
    check(pair(1), 2'h1);
    for (int c = 0; c < 2; c++) begin
      t_truth(c);
      t_dtype(c);
      st[c] = 1'b1;
      t_direct(c);
      t_freeze(c);
    end
    wrap_up();
  end
  initial begin
    #40000;
    n_errors++;
    wrap_up();
  end
endmodule : dual_jk_edge_flip_flop_test
`default_nettype wire

// [bench/pin_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input  wire logic       clk,
  output var  logic [1:0] edge_clock,
  output var  logic [1:0] j_in,
  output var  logic [1:0] k_n_in,
  output var  logic [1:0] direct_preset_n,
  output var  logic [1:0] direct_clear_n
);
  // ==========================================================
  // Pin levels: direct inputs idle high, clock low
  initial begin
    edge_clock      = 2'h0;
    j_in            = 2'h0;
    k_n_in          = 2'h0;
    direct_preset_n = 2'h3;
    direct_clear_n  = 2'h3;
  end
  // Eight clk of settling covers the four-edge pin latency
  task automatic pins(input int c, input logic j, input logic kn, input logic p, input logic cl);
    @(posedge clk);
    j_in[c]            <= j;
    k_n_in[c]          <= kn;
    direct_preset_n[c] <= p;
    direct_clear_n[c]  <= cl;
    repeat (8) @(posedge clk);
  endtask : pins
  // Wide phases so short pulses are never lost in the filter
  task automatic pulse(input int c);
    @(posedge clk);
    edge_clock[c] <= 1'b1;
    repeat (6) @(posedge clk);
    edge_clock[c] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : pulse
endmodule : pin_partner
`default_nettype wire

// [core/dual_jk_edge_flip_flop.sv]
`timescale 1ns/1ps
`default_nettype none
module dual_jk_edge_flip_flop (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  input  wire logic [dual_jk_pkg::CELLS-1:0] edge_clock,
  input  wire logic [dual_jk_pkg::CELLS-1:0] j_in,
  input  wire logic [dual_jk_pkg::CELLS-1:0] k_n_in,
  input  wire logic [dual_jk_pkg::CELLS-1:0] direct_preset_n,
  input  wire logic [dual_jk_pkg::CELLS-1:0] direct_clear_n,
  output var  logic [dual_jk_pkg::CELLS-1:0] state_out,
  output var  logic [dual_jk_pkg::CELLS-1:0] state_out_n
);

  localparam int N = dual_jk_pkg::CELLS;

  // ==========================================================
  // Pin synchronisers, all pins of both cells in one bank
  logic [dual_jk_pkg::SYNC_W-1:0] pins_raw;
  logic [dual_jk_pkg::SYNC_W-1:0] pins_s;
  logic [N-1:0]                   clk_s;
  logic [N-1:0]                   j_s;
  logic [N-1:0]                   kn_s;
  logic [N-1:0]                   pre_s;
  logic [N-1:0]                   clr_s;

  assign pins_raw = {direct_clear_n, direct_preset_n, k_n_in, j_in, edge_clock};

  pin_sync #(
    .W       (dual_jk_pkg::SYNC_W),
    .RST_VAL (dual_jk_pkg::SYNC_RST)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   (pins_raw),
    .q   (pins_s)
  );

  assign clk_s = pins_s[dual_jk_pkg::CLK_LSB +: N];
  assign j_s   = pins_s[dual_jk_pkg::J_LSB   +: N];
  assign kn_s  = pins_s[dual_jk_pkg::KN_LSB  +: N];
  assign pre_s = pins_s[dual_jk_pkg::PRE_LSB +: N];
  assign clr_s = pins_s[dual_jk_pkg::CLR_LSB +: N];

  // ==========================================================
  // Next-state of one cell from {J, K-bar}
  function automatic logic jk_next(input logic j, input logic kn, input logic q);
    logic r;
    r = q;
    case (dual_jk_pkg::jk_action_t'({j, kn}))
      dual_jk_pkg::JK_CLEAR:  r = 1'b0;
      dual_jk_pkg::JK_TOGGLE: r = ~q;
      dual_jk_pkg::JK_HOLD:   r = q;
      dual_jk_pkg::JK_SET:    r = 1'b1;
      default:                r = q;
    endcase
    return r;
  endfunction : jk_next

  // ==========================================================
  // Cell state; each index touches only its own pins
  logic [N-1:0] clk_prev_r;
  logic [N-1:0] clk_prev_nxt;
  logic [N-1:0] j_prev_r;
  logic [N-1:0] j_prev_nxt;
  logic [N-1:0] kn_prev_r;
  logic [N-1:0] kn_prev_nxt;
  logic [N-1:0] q_r;
  logic [N-1:0] q_nxt;
  logic [N-1:0] q_out_r;
  logic [N-1:0] q_out_nxt;
  logic [N-1:0] q_n_out_r;
  logic [N-1:0] q_n_out_nxt;
  logic [N-1:0] rise;
  logic [N-1:0] async_ok;

  always_comb begin
    for (int i = 0; i < N; i++) begin
      // Edge seen only as a change of the filtered level, so slow edges give one event
      rise[i]         = clk_s[i] & ~clk_prev_r[i];
      async_ok[i]     = pre_s[i] & clr_s[i];
      // Data from the cycle before the edge: stands in for the setup window
      clk_prev_nxt[i] = clk_s[i];
      j_prev_nxt[i]   = j_s[i];
      kn_prev_nxt[i]  = kn_s[i];
      q_nxt[i]        = q_r[i];
      if (!pre_s[i]) begin
        q_nxt[i] = 1'b1;
      end else if (!clr_s[i]) begin
        q_nxt[i] = 1'b0;
      end else if (rise[i]) begin
        q_nxt[i] = jk_next(j_prev_r[i], kn_prev_r[i], q_r[i]);
      end
      // Both direct inputs low: both outputs high, state left preset
      q_out_nxt[i]   = q_nxt[i] | ~pre_s[i];
      q_n_out_nxt[i] = ~q_nxt[i] | ~clr_s[i];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clk_prev_r <= '0;
      j_prev_r   <= '0;
      kn_prev_r  <= '0;
      q_r        <= {N{dual_jk_pkg::STATE_RST}};
      q_out_r    <= {N{dual_jk_pkg::STATE_RST}};
      q_n_out_r  <= {N{~dual_jk_pkg::STATE_RST}};
    end else if (ce) begin
      clk_prev_r <= clk_prev_nxt;
      j_prev_r   <= j_prev_nxt;
      kn_prev_r  <= kn_prev_nxt;
      q_r        <= q_nxt;
      q_out_r    <= q_out_nxt;
      q_n_out_r  <= q_n_out_nxt;
    end
  end

  assign state_out   = q_out_r;
  assign state_out_n = q_n_out_r;

  // ==========================================================
  // Checks, one set per cell
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  for (genvar g = 0; g < N; g++) begin : g_chk

    property p_preset;
      (ce && !pre_s[g] && clr_s[g]) |=> (q_out_r[g] && !q_n_out_r[g]);
    endproperty
    a_preset: assert property (p_preset)
      else $error("preset did not force true high");

    property p_clear;
      (ce && pre_s[g] && !clr_s[g]) |=> (!q_out_r[g] && q_n_out_r[g]);
    endproperty
    a_clear: assert property (p_clear)
      else $error("clear did not force true low");

    property p_both_low;
      (ce && !pre_s[g] && !clr_s[g]) |=> (q_out_r[g] && q_n_out_r[g]);
    endproperty
    a_both_low: assert property (p_both_low)
      else $error("both direct low did not give both outputs high");

    property p_jk_set;
      (ce && async_ok[g] && rise[g] && j_prev_r[g] && kn_prev_r[g]) |=> q_r[g];
    endproperty
    a_jk_set: assert property (p_jk_set)
      else $error("set action failed");

    property p_jk_clear;
      (ce && async_ok[g] && rise[g] && !j_prev_r[g] && !kn_prev_r[g]) |=> !q_r[g];
    endproperty
    a_jk_clear: assert property (p_jk_clear)
      else $error("clear action failed");

    property p_jk_toggle;
      (ce && async_ok[g] && rise[g] && j_prev_r[g] && !kn_prev_r[g])
        |=> (q_r[g] != $past(q_r[g]));
    endproperty
    a_jk_toggle: assert property (p_jk_toggle)
      else $error("toggle action failed");

    property p_no_edge_hold;
      (ce && async_ok[g] && !(rise[g] && (j_prev_r[g] || !kn_prev_r[g])))
        |=> $stable(q_r[g]);
    endproperty
    a_no_edge_hold: assert property (p_no_edge_hold)
      else $error("state moved without an acting edge");

    property p_one_update;
      (ce && rise[g]) |=> !rise[g];
    endproperty
    a_one_update: assert property (p_one_update)
      else $error("one clock edge seen twice");

    property p_tied_d;
      (ce && async_ok[g] && rise[g] && (j_prev_r[g] == kn_prev_r[g]))
        |=> (q_r[g] == $past(j_prev_r[g]));
    endproperty
    a_tied_d: assert property (p_tied_d)
      else $error("tied inputs did not load as D");

    property p_outputs_follow;
      (ce && async_ok[g]) |=> (q_out_r[g] == q_r[g] && q_n_out_r[g] == !q_r[g]);
    endproperty
    a_outputs_follow: assert property (p_outputs_follow)
      else $error("outputs differ from clocked state");

    property p_edge_ignored;
      (ce && !pre_s[g] && clr_s[g]) ##1 (ce && async_ok[g] && !rise[g])
        |=> q_r[g];
    endproperty
    a_edge_ignored: assert property (p_edge_ignored)
      else $error("edge during direct input acted late");

    // Edge under a direct input must never reach the JK path
    property p_edge_blocked;
      (ce && !async_ok[g] && rise[g]) |=> (q_r[g] == !$past(pre_s[g]));
    endproperty
    a_edge_blocked: assert property (p_edge_blocked)
      else $error("clock edge acted while a direct input was low");

    property p_frozen;
      !ce |=> ($stable(q_r[g]) && $stable(q_out_r[g]) && $stable(q_n_out_r[g]));
    endproperty
    a_frozen: assert property (p_frozen)
      else $error("state moved while clock enable was low");

    // Main scenarios

    cover property (ce && async_ok[g] && rise[g] && j_prev_r[g] && !kn_prev_r[g]);
    cover property (ce && !pre_s[g] && clr_s[g] ##1 ce && async_ok[g]);
    cover property (ce && !pre_s[g] && !clr_s[g]);
    cover property (ce && !async_ok[g] && rise[g]);
    cover property (!ce ##1 ce);
  end

endmodule : dual_jk_edge_flip_flop
`default_nettype wire

// [core/dual_jk_pkg.sv]
// Overview of operation
// - The block holds two storage cells that share no state or pins; only clk, rst and ce are common to both.
// - A cell changes its clocked state only on a low-to-high change of its own clock pin.
// - Capture depends on the edge alone, and one qualifying edge gives exactly one update.
// - On a rising edge with both direct inputs high, J/K-bar 00 clears, 10 toggles, 01 holds, 11 sets.
// - J and K-bar are taken as they stood just before the edge; with no rising edge the state holds.
// - With J and K-bar tied together, a cell loads the shared value on each rising edge.
// - A low direct preset drives the true output high and the complement low without a clock edge.
// - A low direct clear drives the true output low and the complement high without a clock edge.
// - Direct preset and direct clear low together drive both outputs high.
package dual_jk_pkg;

  // ==========================================================
  // Cell count and synchroniser bit layout
  localparam int CELLS   = 2;
  localparam int SYNC_W  = 5 * CELLS;
  localparam int CLK_LSB = 0;
  localparam int J_LSB   = 2;
  localparam int KN_LSB  = 4;
  localparam int PRE_LSB = 6;
  localparam int CLR_LSB = 8;

  // ==========================================================
  // Reset values: direct inputs idle high, clock and data low
  localparam logic [SYNC_W-1:0] SYNC_RST  = 10'h3C0;
  localparam logic              STATE_RST = 1'b0;

  // ==========================================================
  // Action selected by {J, K-bar}
  typedef enum logic [1:0] {
    JK_CLEAR  = 2'b00,
    JK_HOLD   = 2'b01,
    JK_TOGGLE = 2'b10,
    JK_SET    = 2'b11
  } jk_action_t;

endpackage : dual_jk_pkg

// [core/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  // ==========================================================
  // Three-stage capture; a level counts once stages two and three agree
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    q_nxt = ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & q_r);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      q_r  <= RST_VAL;
    end else if (ce) begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign q = q_r;

endmodule : pin_sync
`default_nettype wire
